/* design/buck_supervisor.sv */
// buck soft-start sequencer and fault supervisor
// assumes comparator levels and pins are asynchronous; analog slew outside
// Notes on behaviour
// - soft-start begins only when supply-good and enable are both high
// - voltage-select inputs are captured when enable rises; that is the start target
// - reference at target sets done flag, power-good high, voltage-step mode
// - after soft-start, new selections are tracked by the limited step source
// - overcurrent held past its filter time latches the converter off
// - overcurrent selects the lowest power-good pull-down code
// - overcurrent and undervoltage latches clear on enable low or supply loss
// - feedback above rising overvoltage threshold past filter declares overvoltage
// - overvoltage latches off and selects the middle pull-down code
// - overvoltage latch clears only on supply loss, not on enable
// - in overvoltage, low-side follows feedback rising and falling thresholds, filtered
// - feedback below undervoltage threshold past filter latches off, highest code
// - over-temperature forces both drives low, power-good and latches untouched
// - over-temperature ends on cooling, enable low or supply loss
// - other detectors stay active during over-temperature
// - reference ramp starts a fixed delay after enable rises
// - continuous conduction forced until soft-start completes
// - supply-good detector is deglitched before use
module buck_supervisor #(
    parameter int OC_CYC = supervisor_pkg::OC_FILTER_CYC,
    parameter int FB_CYC = supervisor_pkg::FB_FILTER_CYC,
    parameter int POR_CYC = supervisor_pkg::SUPPLY_FILTER_CYC,
    parameter int DELAY_CYC = supervisor_pkg::START_DELAY_CYC
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic SUPPLY_ABOVE_POR,
    input wire logic ENABLE_IN,
    input wire logic [supervisor_pkg::VSEL_W-1:0] VOLTAGE_SELECT_INPUTS,
    input wire logic EXT_REF_CHANGED,
    input wire logic REF_AT_TARGET,
    input wire logic OVERCURRENT_SENSE_ABOVE_OUTPUT,
    input wire logic FEEDBACK_ABOVE_OV_RISING,
    input wire logic FEEDBACK_ABOVE_OV_FALLING,
    input wire logic FEEDBACK_BELOW_UV,
    input wire logic TEMP_ABOVE_RISING,
    input wire logic TEMP_BELOW_HYSTERESIS,
    input wire logic PWM_HIGH_REQ,
    input wire logic PWM_LOW_REQ,
    output logic REF_CLAMP_RELEASE,
    output logic REF_AMP_ENABLE,
    output logic SOFTSTART_RAMP,
    output logic STEP_MODE,
    output logic [supervisor_pkg::VSEL_W-1:0] TARGET_SELECT,
    output logic SOFTSTART_DONE_FLAG,
    output logic POWER_GOOD_OUT,
    output logic [1:0] PG_PULLDOWN_CODE,
    output logic CONTINUOUS_CONDUCTION,
    output logic HIGH_SIDE_DRIVE,
    output logic LOW_SIDE_DRIVE,
    output logic OVERCURRENT_FAULT,
    output logic OVERVOLTAGE_FAULT,
    output logic UNDERVOLTAGE_FAULT,
    output logic OVERTEMP_ACTIVE
);
    localparam int DW = $clog2(DELAY_CYC + 1);
    localparam logic [DW-1:0] DELAY_LIMIT = DW'(DELAY_CYC);

    // three-stage synchronisers for pins that are not filtered counters
    logic [2:0] en_sync_r, en_sync_nxt;
    logic [2:0] ot_sync_r, ot_sync_nxt;
    logic [2:0] cool_sync_r, cool_sync_nxt;
    logic [2:0] rdy_sync_r, rdy_sync_nxt;
    logic [2:0] ext_sync_r, ext_sync_nxt;
    logic [2:0] pwmh_sync_r, pwmh_sync_nxt;
    logic [2:0] pwml_sync_r, pwml_sync_nxt;
    logic [supervisor_pkg::VSEL_W-1:0] vs1_r, vs2_r, vs3_r;
    logic en_lvl_r, en_lvl_nxt;
    logic ot_lvl, cool_lvl, rdy_lvl, ext_lvl, pwmh_lvl, pwml_lvl;
    logic en_rise, en_fall;

    always_comb begin
        en_sync_nxt = {en_sync_r[1:0], ENABLE_IN};
        ot_sync_nxt = {ot_sync_r[1:0], TEMP_ABOVE_RISING};
        cool_sync_nxt = {cool_sync_r[1:0], TEMP_BELOW_HYSTERESIS};
        rdy_sync_nxt = {rdy_sync_r[1:0], REF_AT_TARGET};
        ext_sync_nxt = {ext_sync_r[1:0], EXT_REF_CHANGED};
        pwmh_sync_nxt = {pwmh_sync_r[1:0], PWM_HIGH_REQ};
        pwml_sync_nxt = {pwml_sync_r[1:0], PWM_LOW_REQ};
        // enable changes only once stages two and three agree; other levels need both stages high
        en_lvl_nxt = (en_sync_r[1] == en_sync_r[2]) ? en_sync_r[2] : en_lvl_r;
        ot_lvl = ot_sync_r[1] & ot_sync_r[2];
        cool_lvl = cool_sync_r[1] & cool_sync_r[2];
        rdy_lvl = rdy_sync_r[1] & rdy_sync_r[2];
        ext_lvl = ext_sync_r[1] & ext_sync_r[2];
        pwmh_lvl = pwmh_sync_r[1] & pwmh_sync_r[2];
        pwml_lvl = pwml_sync_r[1] & pwml_sync_r[2];
        en_rise = en_lvl_nxt & ~en_lvl_r;
        en_fall = ~en_lvl_nxt & en_lvl_r;
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            en_sync_r <= '0;
            ot_sync_r <= '0;
            cool_sync_r <= '0;
            rdy_sync_r <= '0;
            ext_sync_r <= '0;
            pwmh_sync_r <= '0;
            pwml_sync_r <= '0;
            vs1_r <= supervisor_pkg::VSEL_RESET;
            vs2_r <= supervisor_pkg::VSEL_RESET;
            vs3_r <= supervisor_pkg::VSEL_RESET;
            en_lvl_r <= 1'b0;
        end else begin
            en_sync_r <= en_sync_nxt;
            ot_sync_r <= ot_sync_nxt;
            cool_sync_r <= cool_sync_nxt;
            rdy_sync_r <= rdy_sync_nxt;
            ext_sync_r <= ext_sync_nxt;
            pwmh_sync_r <= pwmh_sync_nxt;
            pwml_sync_r <= pwml_sync_nxt;
            vs1_r <= VOLTAGE_SELECT_INPUTS;
            vs2_r <= vs1_r;
            vs3_r <= vs2_r;
            en_lvl_r <= en_lvl_nxt;
        end
    end

    // filtered comparators; supply filter acts on both crossings
    fault_filter_if oc_if ();
    fault_filter_if ovr_if ();
    fault_filter_if ovf_if ();
    fault_filter_if uv_if ();
    fault_filter_if por_if ();
    fault_filter_if porl_if ();
    assign oc_if.raw = OVERCURRENT_SENSE_ABOVE_OUTPUT;
    assign ovr_if.raw = FEEDBACK_ABOVE_OV_RISING;
    assign ovf_if.raw = ~FEEDBACK_ABOVE_OV_FALLING;
    assign uv_if.raw = FEEDBACK_BELOW_UV;
    assign por_if.raw = SUPPLY_ABOVE_POR;
    assign porl_if.raw = ~SUPPLY_ABOVE_POR;

    comparator_filter #(.CYCLES(OC_CYC)) u_oc (.clk(CORE_CLK), .nrst(NRST), .port_if(oc_if));
    comparator_filter #(.CYCLES(FB_CYC)) u_ovr (.clk(CORE_CLK), .nrst(NRST), .port_if(ovr_if));
    comparator_filter #(.CYCLES(FB_CYC)) u_ovf (.clk(CORE_CLK), .nrst(NRST), .port_if(ovf_if));
    comparator_filter #(.CYCLES(FB_CYC)) u_uv (.clk(CORE_CLK), .nrst(NRST), .port_if(uv_if));
    comparator_filter #(.CYCLES(POR_CYC)) u_por (.clk(CORE_CLK), .nrst(NRST), .port_if(por_if));
    comparator_filter #(.CYCLES(POR_CYC)) u_porl (.clk(CORE_CLK), .nrst(NRST), .port_if(porl_if));

    // supply-good held between deglitched crossings
    logic supply_ok_r, supply_ok_nxt;
    logic supply_loss;
    supervisor_pkg::seq_state_t state_r, state_nxt;
    logic [DW-1:0] dly_r, dly_nxt;
    logic [supervisor_pkg::VSEL_W-1:0] target_r, target_nxt;
    logic oc_r, oc_nxt, ov_r, ov_nxt, uv_r, uv_nxt, ot_r, ot_nxt;
    logic [1:0] code_r, code_nxt;
    logic lsd_ov_r, lsd_ov_nxt;
    logic pg_r, pg_nxt, done_r, done_nxt;
    logic hs_r, hs_nxt, ls_r, ls_nxt;
    logic latched_off;

    always_comb begin
        supply_ok_nxt = supply_ok_r;
        if (por_if.qualified) begin
            supply_ok_nxt = 1'b1;
        end else if (porl_if.qualified) begin
            supply_ok_nxt = 1'b0;
        end
        supply_loss = supply_ok_r & ~supply_ok_nxt;
        latched_off = oc_r | ov_r | uv_r;

        // fault latches; clear terms follow each fault's own reset source
        oc_nxt = oc_r;
        uv_nxt = uv_r;
        ov_nxt = ov_r;
        if (en_fall || supply_loss) begin
            oc_nxt = 1'b0;
            uv_nxt = 1'b0;
        end
        if (supply_loss) begin
            ov_nxt = 1'b0;
        end
        // detectors stay armed while latched off, so a later fault is still recorded
        if ((state_r != supervisor_pkg::ST_OFF || latched_off) &&
            supply_ok_r && !supply_loss) begin
            if (oc_if.qualified) begin
                oc_nxt = 1'b1;
            end
            if (ovr_if.qualified) begin
                ov_nxt = 1'b1;
            end
            // kept live through over-temperature
            if (uv_if.qualified) begin
                uv_nxt = 1'b1;
            end
        end

        // first latched fault owns the code
        code_nxt = code_r;
        if (!oc_nxt && !ov_nxt && !uv_nxt) begin
            code_nxt = supervisor_pkg::PG_CODE_NONE;
        end else if (code_r == supervisor_pkg::PG_CODE_NONE) begin
            if (oc_nxt) begin
                code_nxt = supervisor_pkg::PG_CODE_LOW;
            end else if (ov_nxt) begin
                code_nxt = supervisor_pkg::PG_CODE_MID;
            end else begin
                code_nxt = supervisor_pkg::PG_CODE_HIGH;
            end
        end

        // held clear while enable or supply is missing, else a hot die re-enters at once
        ot_nxt = ot_r;
        if (!en_lvl_nxt || !supply_ok_nxt) begin
            ot_nxt = 1'b0;
        end else if (ot_lvl) begin
            ot_nxt = 1'b1;
        end else if (cool_lvl) begin
            ot_nxt = 1'b0;
        end

        // low-side discharge while latched for overvoltage
        lsd_ov_nxt = lsd_ov_r;
        if (!ov_nxt) begin
            lsd_ov_nxt = 1'b0;
        end else if (ovr_if.qualified) begin
            lsd_ov_nxt = 1'b1;
        end else if (ovf_if.qualified) begin
            lsd_ov_nxt = 1'b0;
        end

        state_nxt = state_r;
        dly_nxt = dly_r;
        target_nxt = target_r;
        if (en_rise) begin
            target_nxt = vs3_r;
        end
        unique case (state_r)
            supervisor_pkg::ST_OFF: begin
                dly_nxt = '0;
                if (supply_ok_r && en_lvl_r && !latched_off) begin
                    state_nxt = supervisor_pkg::ST_DELAY;
                end
            end
            supervisor_pkg::ST_DELAY: begin
                if (dly_r == DELAY_LIMIT) begin
                    state_nxt = supervisor_pkg::ST_RAMP;
                end else begin
                    dly_nxt = dly_r + DW'(1);
                end
            end
            supervisor_pkg::ST_RAMP: begin
                if (rdy_lvl) begin
                    state_nxt = supervisor_pkg::ST_RUN;
                end
            end
            supervisor_pkg::ST_RUN: begin
                // later selections follow live inputs through the step source
                target_nxt = vs3_r;
            end
        endcase
        if (!supply_ok_nxt || !en_lvl_nxt || latched_off) begin
            state_nxt = supervisor_pkg::ST_OFF;
        end

        done_nxt = (state_nxt == supervisor_pkg::ST_RUN);
        pg_nxt = done_nxt && !(oc_nxt || ov_nxt || uv_nxt);

        // drive priority: over-temperature, then faults, then modulator
        hs_nxt = 1'b0;
        ls_nxt = 1'b0;
        if (ot_nxt) begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b0;
        end else if (ov_nxt) begin
            ls_nxt = lsd_ov_nxt;
        end else if (!oc_nxt && !uv_nxt &&
                     (state_nxt == supervisor_pkg::ST_RAMP ||
                      state_nxt == supervisor_pkg::ST_RUN)) begin
            hs_nxt = pwmh_lvl;
            ls_nxt = pwml_lvl & ~pwmh_lvl;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            supply_ok_r <= 1'b0;
            state_r <= supervisor_pkg::ST_OFF;
            dly_r <= '0;
            target_r <= supervisor_pkg::VSEL_RESET;
            oc_r <= 1'b0;
            ov_r <= 1'b0;
            uv_r <= 1'b0;
            ot_r <= 1'b0;
            code_r <= supervisor_pkg::PG_CODE_NONE;
            lsd_ov_r <= 1'b0;
            pg_r <= 1'b0;
            done_r <= 1'b0;
            hs_r <= 1'b0;
            ls_r <= 1'b0;
        end else begin
            supply_ok_r <= supply_ok_nxt;
            state_r <= state_nxt;
            dly_r <= dly_nxt;
            target_r <= target_nxt;
            oc_r <= oc_nxt;
            ov_r <= ov_nxt;
            uv_r <= uv_nxt;
            ot_r <= ot_nxt;
            code_r <= code_nxt;
            lsd_ov_r <= lsd_ov_nxt;
            pg_r <= pg_nxt;
            done_r <= done_nxt;
            hs_r <= hs_nxt;
            ls_r <= ls_nxt;
        end
    end

    // status outputs are decoded from the next state and registered, so they come straight off flops
    logic ramp_r, step_r, clamp_r, ccm_r;
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ramp_r <= 1'b0;
            step_r <= 1'b0;
            clamp_r <= 1'b0;
            ccm_r <= 1'b1;
        end else begin
            ramp_r <= (state_nxt == supervisor_pkg::ST_RAMP);
            step_r <= (state_nxt == supervisor_pkg::ST_RUN) || ext_lvl & step_r;
            clamp_r <= (state_nxt != supervisor_pkg::ST_OFF);
            ccm_r <= (state_nxt != supervisor_pkg::ST_RUN);
        end
    end

    assign REF_CLAMP_RELEASE = clamp_r;
    assign REF_AMP_ENABLE = clamp_r;
    assign SOFTSTART_RAMP = ramp_r;
    assign STEP_MODE = step_r;
    assign TARGET_SELECT = target_r;
    assign SOFTSTART_DONE_FLAG = done_r;
    assign POWER_GOOD_OUT = pg_r;
    assign PG_PULLDOWN_CODE = code_r;
    assign CONTINUOUS_CONDUCTION = ccm_r;
    assign HIGH_SIDE_DRIVE = hs_r;
    assign LOW_SIDE_DRIVE = ls_r;
    assign OVERCURRENT_FAULT = oc_r;
    assign OVERVOLTAGE_FAULT = ov_r;
    assign UNDERVOLTAGE_FAULT = uv_r;
    assign OVERTEMP_ACTIVE = ot_r;

    a_ot_drives_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        ot_r |-> !hs_r && !ls_r) else $error("drive active in over-temperature");
    a_oc_code_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $rose(oc_r) && !ov_r && !uv_r |-> code_r == 2'h3)
        else $error("overcurrent code wrong");
    a_ov_code_mid: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $rose(ov_r) && !oc_r && !uv_r |-> code_r == 2'h2)
        else $error("overvoltage code wrong");
    a_uv_code_high: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $rose(uv_r) && !oc_r && !ov_r |-> code_r == 2'h1)
        else $error("undervoltage code wrong");
    a_ov_kept_enable: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        ov_r && supply_ok_r && supply_ok_nxt |=> ov_r)
        else $error("overvoltage cleared without supply loss");
    a_pg_needs_done: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        pg_r |-> done_r && !ccm_r) else $error("power-good before soft-start done");
    a_ramp_after_delay: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $rose(ramp_r) |-> $past(state_r) == supervisor_pkg::ST_DELAY && $past(dly_r) == DELAY_LIMIT)
        else $error("ramp started before delay");
    a_start_needs_both: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $rose(clamp_r) |-> $past(supply_ok_r) && $past(en_lvl_r))
        else $error("start without supply and enable");
    a_fault_stops_high: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (oc_r || uv_r || ov_r) |-> !hs_r) else $error("high side on while latched");
endmodule // buck_supervisor

/* design/supervisor_pkg.sv */
// package: timing counts, power-good codes and sequencer states for the buck supervisor
// assumes a single 40 MHz core clock; comparator levels arrive asynchronous
package supervisor_pkg;
    localparam int CLK_MHZ = 40;
    localparam int OC_FILTER_NS = 10000;
    localparam int OC_FILTER_CYC = (OC_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int FB_FILTER_NS = 2000;
    localparam int FB_FILTER_CYC = (FB_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int SUPPLY_FILTER_NS = 1000;
    localparam int SUPPLY_FILTER_CYC = (SUPPLY_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int START_DELAY_NS = 20000;
    localparam int START_DELAY_CYC = (START_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int VSEL_W = 2;
    // power-good pull-down code: none, 95 ohm (uv), 65 ohm (ov), 35 ohm (oc)
    localparam logic [1:0] PG_CODE_NONE = 2'h0;
    localparam logic [1:0] PG_CODE_HIGH = 2'h1;
    localparam logic [1:0] PG_CODE_MID = 2'h2;
    localparam logic [1:0] PG_CODE_LOW = 2'h3;
    localparam logic [VSEL_W-1:0] VSEL_RESET = 2'h0;
    typedef enum logic [1:0] {
        ST_OFF = 2'h0,
        ST_DELAY = 2'h1,
        ST_RAMP = 2'h3,
        ST_RUN = 2'h2
    } seq_state_t;
endpackage

/* design/fault_filter_if.sv */
// interface: one qualified comparator between the supervisor and a filter instance
// assumes raw input already carried on the core clock by the filter itself
interface fault_filter_if;
    logic raw;
    logic qualified;
    modport filt (input raw, output qualified);
    modport user (output raw, input qualified);
endinterface

/* design/comparator_filter.sv */
// comparator qualification: three-stage synchroniser then a restarting counter
// assumes the raw input is asynchronous to the core clock
module comparator_filter #(
    parameter int CYCLES = 80
) (
    input wire logic clk,
    input wire logic nrst,
    fault_filter_if.filt port_if
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(CYCLES);
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic qual_r;
    logic qual_nxt;
    logic level;

    always_comb begin
        sync_nxt = {sync_r[1:0], port_if.raw};
        // only stages two and three are looked at; stage one settles
        level = sync_r[1] & sync_r[2];
        if (!level) begin
            count_nxt = '0;
        end else if (count_r != LIMIT) begin
            count_nxt = count_r + CW'(1);
        end else begin
            count_nxt = count_r;
        end
        qual_nxt = level && (count_r == LIMIT);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_r <= '0;
            count_r <= '0;
            qual_r <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            count_r <= count_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign port_if.qualified = qual_r;

    a_qual_needs_level: assert property (@(posedge clk) disable iff (!nrst)
        qual_r |-> $past(sync_r[2])) else $error("qualified without a held level");
endmodule // comparator_filter

/* verif/ref_cap_model.sv */
// partner: reference node capacitor, reports when the ramp has reached its target
// assumes the bench clock; ramp length is a plain parameter, not a capacitor figure
module ref_cap_model #(
    parameter int RAMP_CYC = 12
) (
    input wire logic clk,
    input wire logic clamp_release,
    input wire logic ramp,
    output logic at_target
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial at_target = 1'b0;
    always @(posedge clk) begin
        // the clamp discharges the node, so the target is lost at once
        if (!clamp_release) begin
            cnt <= 0;
            at_target <= 1'b0;
        end else if (ramp && cnt < RAMP_CYC) begin
            cnt <= cnt + 1;
        end else if (cnt == RAMP_CYC) begin
            at_target <= 1'b1;
        end
    end
endmodule // ref_cap_model

/* verif/buck_softstart_fault_supervisor_test.sv */
// bench: start-up, fault latches, clearing and over-temperature of the supervisor
// assumes short filter counts; the reference node comes from ref_cap_model
module buck_softstart_fault_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OC = 4;
    localparam int FB = 4;
    localparam int DLY = 8;
    localparam int RAMP = 0, DONE = 1, OCF = 2, OVF = 3, UVF = 4, OTA = 5, LOWD = 6;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic supply = 1'b0, enable = 1'b0, ext_ref = 1'b0, oc = 1'b0, ov_r = 1'b0, ov_f = 1'b0;
    logic uv = 1'b0, t_hi = 1'b0, t_lo = 1'b1, pwm_h = 1'b0, pwm_l = 1'b0, at_tgt;
    logic [1:0] vsel = 2'h0;
    logic clamp, amp, ramp, step, done, pg, continuous_conduction, hs, ls, ocf, ovf, uvf, ota;
    logic [1:0] tsel, code;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic seen = 1'b0;
    wire logic [6:0] mon = {ls, ota, uvf, ovf, ocf, done, ramp};

    buck_supervisor #(.OC_CYC(OC), .FB_CYC(FB), .POR_CYC(2), .DELAY_CYC(DLY)) u_buck_supervisor (
        .CORE_CLK(clk), .NRST(nrst), .SUPPLY_ABOVE_POR(supply), .ENABLE_IN(enable),
        .VOLTAGE_SELECT_INPUTS(vsel), .EXT_REF_CHANGED(ext_ref), .REF_AT_TARGET(at_tgt),
        .OVERCURRENT_SENSE_ABOVE_OUTPUT(oc), .FEEDBACK_ABOVE_OV_RISING(ov_r),
        .FEEDBACK_ABOVE_OV_FALLING(ov_f), .FEEDBACK_BELOW_UV(uv), .TEMP_ABOVE_RISING(t_hi),
        .TEMP_BELOW_HYSTERESIS(t_lo), .PWM_HIGH_REQ(pwm_h), .PWM_LOW_REQ(pwm_l),
        .REF_CLAMP_RELEASE(clamp), .REF_AMP_ENABLE(amp), .SOFTSTART_RAMP(ramp),
        .STEP_MODE(step), .TARGET_SELECT(tsel), .SOFTSTART_DONE_FLAG(done),
        .POWER_GOOD_OUT(pg), .PG_PULLDOWN_CODE(code), .CONTINUOUS_CONDUCTION(continuous_conduction),
        .HIGH_SIDE_DRIVE(hs), .LOW_SIDE_DRIVE(ls), .OVERCURRENT_FAULT(ocf),
        .OVERVOLTAGE_FAULT(ovf), .UNDERVOLTAGE_FAULT(uvf), .OVERTEMP_ACTIVE(ota));
    ref_cap_model u_ref_cap_model (.clk(clk), .clamp_release(clamp), .ramp(ramp),
        .at_target(at_tgt));

    always #12.5 clk = ~clk;
    // modulator requests wander freely so the drive gating is exercised
    always @(posedge clk) begin
        {pwm_h, pwm_l} <= 2'($urandom);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pull-down code that each fault kind selects
    function automatic logic [3:0] code_of(input int kind);
        case (kind)
            OCF: return {2'h0, supervisor_pkg::PG_CODE_LOW};
            OVF: return {2'h0, supervisor_pkg::PG_CODE_MID};
            UVF: return {2'h0, supervisor_pkg::PG_CODE_HIGH};
            default: return {2'h0, supervisor_pkg::PG_CODE_NONE};
        endcase
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait on one monitored output; outputs are sampled clear of the edge
    task automatic wait_on(input string what, input int k, input logic v);
        for (int i = 0; i < 200; i++) begin
            if (mon[k] === v) break;
            settle(1);
        end
        chk(what, {3'h0, v}, {3'h0, mon[k]});
    endtask
    task automatic start_up();
        logic [1:0] cap;
        int n;
        cap = 2'($urandom);
        @(posedge clk);
        enable <= 1'b0;
        supply <= 1'b1;
        {oc, ov_r, ov_f, uv, t_hi, t_lo} <= 6'h1;
        vsel <= cap;
        settle(20);
        @(posedge clk);
        enable <= 1'b1;
        n = 0;
        while (ramp !== 1'b1 && n < 100) begin
            settle(1);
            n++;
        end
        chk("ramp delay", 4'(n >= DLY && n <= DLY + 12), 4'h1);
        chk("clamp amp", {2'h0, clamp, amp}, 4'h3);
        @(posedge clk);
        vsel <= ~cap;
        settle(4);
        chk("target", {2'h0, tsel}, {2'h0, cap});
        chk("ccm ramp", {3'h0, continuous_conduction}, 4'h1);
        wait_on("done", DONE, 1'b1);
        settle(6);
        chk("run", {pg, step, continuous_conduction, 1'b0}, 4'hC);
        chk("follow", {2'h0, tsel}, {2'h0, ~cap});
        @(posedge clk);
        ext_ref <= 1'b1;
        settle(5);
        chk("ext step", {3'h0, step}, 4'h1);
        @(posedge clk);
        ext_ref <= 1'b0;
    endtask

    initial begin
        void'($urandom(32'h2946));
        settle(1);
        chk("reset", {continuous_conduction, pg, done, ls}, 4'h8);
        @(posedge clk);
        nrst <= 1'b1;
        start_up();
        // one-cycle supply dip is shorter than the detector's filter
        @(posedge clk);
        supply <= 1'b0;
        @(posedge clk);
        supply <= 1'b1;
        settle(12);
        chk("dip", {3'h0, pg}, 4'h1);
        @(posedge clk);
        oc <= 1'b1;
        settle(OC - 2);
        @(posedge clk);
        oc <= 1'b0;
        settle(15);
        chk("oc glitch", {3'h0, ocf}, 4'h0);
        @(posedge clk);
        oc <= 1'b1;
        wait_on("oc", OCF, 1'b1);
        settle(2);
        chk("oc off", {pg, hs, ls, 1'b0}, 4'h0);
        chk("oc code", {2'h0, code}, code_of(OCF));
        @(posedge clk);
        uv <= 1'b1;
        settle(FB + 12);
        chk("first code", {uvf, 1'b0, code}, 4'h8 | code_of(OCF));
        @(posedge clk);
        {oc, uv, enable} <= 3'h0;
        wait_on("oc clear", OCF, 1'b0);
        start_up();
        @(posedge clk);
        {ov_r, ov_f} <= 2'h3;
        wait_on("ov", OVF, 1'b1);
        settle(2);
        chk("ov code", {pg, 1'b0, code}, code_of(OVF));
        wait_on("low on", LOWD, 1'b1);
        @(posedge clk);
        ov_r <= 1'b0;
        settle(FB + 10);
        chk("low held", {3'h0, ls}, 4'h1);
        @(posedge clk);
        ov_f <= 1'b0;
        wait_on("low off", LOWD, 1'b0);
        @(posedge clk);
        enable <= 1'b0;
        settle(20);
        chk("ov kept", {3'h0, ovf}, 4'h1);
        @(posedge clk);
        supply <= 1'b0;
        wait_on("ov clear", OVF, 1'b0);
        start_up();
        @(posedge clk);
        {t_hi, t_lo} <= 2'h2;
        wait_on("ot", OTA, 1'b1);
        settle(3);
        chk("ot drives", {hs, ls, pg, ocf | ovf | uvf}, 4'h2);
        @(posedge clk);
        {t_hi, t_lo} <= 2'h1;
        wait_on("ot end", OTA, 1'b0);
        seen = 1'b0;
        repeat (30) begin
            settle(1);
            seen = seen | hs;
        end
        chk("resume", {3'h0, seen}, 4'h1);
        @(posedge clk);
        {t_hi, t_lo} <= 2'h2;
        wait_on("ot again", OTA, 1'b1);
        @(posedge clk);
        uv <= 1'b1;
        wait_on("uv", UVF, 1'b1);
        settle(2);
        chk("uv code", {pg, 1'b0, code}, code_of(UVF));
        @(posedge clk);
        {uv, enable} <= 2'h0;
        wait_on("uv clear", UVF, 1'b0);
        wait_on("ot reset", OTA, 1'b0);
        conclude();
    end
endmodule // buck_softstart_fault_supervisor_test
